/* File: ramb_fabric.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Fabric-side user logic that presents requests to both RAM ports.
// ---------------------------------------------------------------------------
module ramb_fabric #(
  parameter int AW = 5,
  parameter int W = 18,
  parameter int MW = 2
) (
  output logic [AW-1:0] a_addr,
  output logic [W-1:0] a_data,
  output logic a_wren,
  output logic [MW-1:0] a_lanes,
  output logic [AW-1:0] b_addr,
  output logic [W-1:0] b_data,
  output logic b_wren,
  output logic [MW-1:0] b_lanes
);
  // Every line has a defined level from time zero.
  initial begin
    a_addr = '0;
    a_data = '0;
    a_wren = 1'b0;
    a_lanes = '1;
    b_addr = '0;
    b_data = '0;
    b_wren = 1'b0;
    b_lanes = '1;
  end

  // Presents one request; called just after a falling edge only.
  // Data of a read is meaningless, so it is inverted rather than held,
  // which keeps a design that wrongly samples it from passing by luck.
  task automatic put(input bit pb, input logic [AW-1:0] ad,
                     input logic [W-1:0] d, input logic wr,
                     input logic [MW-1:0] ln);
    if (pb) begin
      b_addr = ad;
      b_data = wr ? d : ~b_data;
      b_wren = wr;
      b_lanes = ln;
    end else begin
      a_addr = ad;
      a_data = wr ? d : ~a_data;
      a_wren = wr;
      a_lanes = ln;
    end
  endtask
endmodule

/* File: ramb_inreg.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Input register stage of one port.
// ---------------------------------------------------------------------------
module ramb_inreg #(
  parameter int AW = 6,
  parameter int W = 18,
  parameter int MW = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic aclr,
  input wire logic [AW-1:0] addr_i,
  input wire logic [W-1:0] data_i,
  input wire logic wren_i,
  input wire logic [MW-1:0] lanes_i,
  ramb_port_if.regs p
);

  // Everything that the asynchronous clear reaches.
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [W-1:0] data;
    logic wren;
  } ramb_in_t;

  ramb_in_t state_r; // Registered request.
  ramb_in_t state_nxt; // Its next value.
  logic [MW-1:0] lanes_r; // Lane mask register, outside the clear.

  // Next request: the pins, or cleared under the synchronous reset.
  always_comb begin
    state_nxt.addr = addr_i;
    state_nxt.data = data_i;
    state_nxt.wren = wren_i;
    if (!rst_n) begin
      state_nxt = '{default: ramb_pkg::IN_CLEAR};
    end
  end

  // The clear empties the stage at once; a pending write is dropped.
  always_ff @(posedge clk or posedge aclr) begin
    if (aclr) begin
      state_r <= '{default: ramb_pkg::IN_CLEAR};
    end else begin
      state_r <= state_nxt;
    end
  end

  // The mask has no clear, so it lives apart from the struct; the
  // synchronous reset loads it with all lanes enabled.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lanes_r <= {MW{ramb_pkg::LANE_ON}};
    end else begin
      lanes_r <= lanes_i;
    end
  end

  assign p.addr = state_r.addr;
  assign p.data = state_r.data;
  assign p.wren = state_r.wren;
  assign p.lanes = lanes_r;

endmodule

/* File: ramb_pkg.sv */
// ---------------------------------------------------------------------------
// Shared constants and helpers of the byte-masked embedded RAM.
// ---------------------------------------------------------------------------
package ramb_pkg;

  // The three block sizes of the family.
  typedef enum logic [1:0] {
    RAMB_SMALL  = 2'b00,
    RAMB_MEDIUM = 2'b01,
    RAMB_LARGE  = 2'b10
  } ramb_size_t;

  // Total storage bits of each size, parity bits included.
  localparam int SMALL_BITS = 576;
  localparam int SMALL_PARITY_BITS = 64;
  localparam int MEDIUM_BITS = 4608;
  localparam int LARGE_BITS = 589824;

  // Lane widths: a plain byte, or a byte with its parity bit.
  localparam int LANE_BITS = 8;
  localparam int PAR_LANE_BITS = 9;

  // Lane mask width of one port for each size.
  localparam int SMALL_MASK_W = 2;
  localparam int MEDIUM_MASK_W = 4;
  localparam int LARGE_MASK_W = 8;

  // Lane count when the two large-block masks are joined.
  localparam int WIDE_LANES = 16;
  localparam int WIDE_W8 = 128;
  localparam int WIDE_W9 = 144;

  // Reset values of the input registers and of the lane masks.
  localparam logic IN_CLEAR = 1'b0;
  localparam logic LANE_ON = 1'b1;

  // Total bits for a size.
  function automatic int total_bits(ramb_size_t s);
    return (s == RAMB_SMALL) ? SMALL_BITS :
           (s == RAMB_MEDIUM) ? MEDIUM_BITS : LARGE_BITS;
  endfunction

  // Lane mask width of one port for a size.
  function automatic int mask_w(ramb_size_t s);
    return (s == RAMB_SMALL) ? SMALL_MASK_W :
           (s == RAMB_MEDIUM) ? MEDIUM_MASK_W : LARGE_MASK_W;
  endfunction

  // Bits per lane: nine when the width carries parity bits.
  function automatic int lane_w(int w);
    return (w % PAR_LANE_BITS == 0) ? PAR_LANE_BITS : LANE_BITS;
  endfunction

  // Words of the given width; parity bits go unused at widths that are not multiples of nine.
  function automatic int depth(ramb_size_t s, int w);
    int t;
    t = total_bits(s);
    if (w % PAR_LANE_BITS != 0) begin
      t = t / PAR_LANE_BITS * LANE_BITS;
    end
    return t / w;
  endfunction

  // Widths that each size serves.
  function automatic bit width_ok(ramb_size_t s, int w);
    bit ok;
    ok = (w == 8) || (w == 9) || (w == 16) || (w == 18);
    if (s != RAMB_LARGE) begin
      ok = ok || (w == 1) || (w == 2) || (w == 4);
    end
    if (s != RAMB_SMALL) begin
      ok = ok || (w == 32) || (w == 36);
    end
    if (s == RAMB_LARGE) begin
      ok = ok || (w == 64) || (w == 72) || (w == WIDE_W8) || (w == WIDE_W9);
    end
    return ok;
  endfunction

endpackage

/* File: ramb_port_if.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Registered request of one port, from its input stage to the core.
// ---------------------------------------------------------------------------
interface ramb_port_if #(
  parameter int AW = 6,
  parameter int W = 18,
  parameter int MW = 2
);
  logic [AW-1:0] addr; // Registered address.
  logic [W-1:0] data; // Registered write data.
  logic wren; // Registered write strobe.
  logic [MW-1:0] lanes; // Registered lane mask.

  modport regs (output addr, output data, output wren, output lanes);
  modport core (input addr, input data, input wren, input lanes);
endinterface

/* File: ramb_top.sv */
`timescale 1ns/1ns

// ---------------------------------------------------------------------------
// Byte-masked dual-port RAM.
// ---------------------------------------------------------------------------
module ramb_top #(
  parameter ramb_pkg::ramb_size_t SIZE = ramb_pkg::RAMB_SMALL,
  parameter int WIDTH = 18,
  parameter int MW = ramb_pkg::mask_w(SIZE),
  parameter int DEPTH = ramb_pkg::depth(SIZE, WIDTH),
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic ACLR_IN,
  input wire logic ACLR_OUT,
  input wire logic [AW-1:0] A_ADDR,
  input wire logic [WIDTH-1:0] A_DATA,
  input wire logic A_WREN,
  input wire logic [MW-1:0] A_LANES,
  output logic [WIDTH-1:0] A_Q,
  input wire logic [AW-1:0] B_ADDR,
  input wire logic [WIDTH-1:0] B_DATA,
  input wire logic B_WREN,
  input wire logic [MW-1:0] B_LANES,
  output logic [WIDTH-1:0] B_Q
);

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------

  // Bits per lane, eight or nine; the ninth is plain storage.
  localparam int LW = ramb_pkg::lane_w(WIDTH);
  // Joined-mask mode of the large block; port B then only reads.
  localparam bit WIDE = (SIZE == ramb_pkg::RAMB_LARGE) &&
    ((WIDTH == ramb_pkg::WIDE_W8) || (WIDTH == ramb_pkg::WIDE_W9));

  // Refuse widths, masks and depths that the block cannot serve.
  if (!ramb_pkg::width_ok(SIZE, WIDTH)) begin : g_bad_width
    $error("Data width not served by this block size.");
  end
  if (MW != ramb_pkg::mask_w(SIZE)) begin : g_bad_mask
    $error("Lane mask width does not match block size.");
  end
  if (DEPTH * WIDTH > ramb_pkg::total_bits(SIZE)) begin : g_bad_depth
    $error("Depth exceeds block capacity.");
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------

  // Spreads a lane mask over the data bits. Below a byte, lane 0
  // covers the whole word; masking a nibble of a byte is impossible
  // by construction, which is why narrow users gate with the strobe.
  function automatic logic [WIDTH-1:0] bit_mask(input logic [15:0] lanes);
    logic [WIDTH-1:0] m;
    m = '0;
    for (int i = 0; i < WIDTH; i++) begin
      m[i] = (WIDTH < ramb_pkg::LANE_BITS) ? lanes[0] : lanes[i / LW];
    end
    return m;
  endfunction

  // Merges new data into the enabled lanes of an old word.
  function automatic logic [WIDTH-1:0] merge(
    input logic [WIDTH-1:0] old_w,
    input logic [WIDTH-1:0] new_w,
    input logic [WIDTH-1:0] m
  );
    return (new_w & m) | (old_w & ~m);
  endfunction

  // ---------------------------------------------------------------------------
  // Input registers of both ports
  // ---------------------------------------------------------------------------

  ramb_port_if #(.AW(AW), .W(WIDTH), .MW(MW)) pa ();
  ramb_port_if #(.AW(AW), .W(WIDTH), .MW(MW)) pb ();

  // Port A request stage.
  ramb_inreg #(.AW(AW), .W(WIDTH), .MW(MW)) u_in_a (
    .clk(CLOCK),
    .rst_n(RESETN),
    .aclr(ACLR_IN),
    .addr_i(A_ADDR),
    .data_i(A_DATA),
    .wren_i(A_WREN),
    .lanes_i(A_LANES),
    .p(pa)
  );

  // Port B request stage.
  ramb_inreg #(.AW(AW), .W(WIDTH), .MW(MW)) u_in_b (
    .clk(CLOCK),
    .rst_n(RESETN),
    .aclr(ACLR_IN),
    .addr_i(B_ADDR),
    .data_i(B_DATA),
    .wren_i(B_WREN),
    .lanes_i(B_LANES),
    .p(pb)
  );

  // ---------------------------------------------------------------------------
  // Lane selection
  // ---------------------------------------------------------------------------

  logic [15:0] lanes_a; // Effective lanes of port A.
  logic [15:0] lanes_b; // Effective lanes of port B.
  logic [WIDTH-1:0] bm_a; // Bit mask of port A.
  logic [WIDTH-1:0] bm_b; // Bit mask of port B.
  logic we_a; // Port A writes this cycle.
  logic we_b; // Port B writes this cycle.

  // In wide mode port B's mask supplies the upper eight lanes of the
  // single write port; otherwise each port uses its own mask.
  always_comb begin
    if (WIDE) begin
      lanes_a = 16'({pb.lanes, pa.lanes});
    end else begin
      lanes_a = 16'(pa.lanes);
    end
    lanes_b = 16'(pb.lanes);
    bm_a = bit_mask(lanes_a);
    bm_b = bit_mask(lanes_b);
  end

  // A write needs the registered strobe; the mask then picks lanes.
  assign we_a = pa.wren;
  assign we_b = pb.wren && !WIDE;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------

  // Every bit of the block; parity lanes only at widths that are multiples of nine.
  logic [WIDTH-1:0] mem [DEPTH];

  logic [WIDTH-1:0] word_a; // Stored word at port A's address.
  logic [WIDTH-1:0] word_b; // Stored word at port B's address.

  assign word_a = mem[pa.addr];
  assign word_b = mem[pb.addr];

  // Writes land on the edge after the request is registered. When
  // both ports write one address, port B is applied last; users must
  // keep such collisions apart, as the result is not defined.
  always_ff @(posedge CLOCK) begin
    if (we_a) begin
      mem[pa.addr] <= merge(word_a, pa.data, bm_a);
    end
    if (we_b) begin
      mem[pb.addr] <= merge(word_b, pb.data, bm_b);
    end
  end

  // ---------------------------------------------------------------------------
  // Read path and output registers
  // ---------------------------------------------------------------------------

  // Output register contents.
  typedef struct packed {
    logic [WIDTH-1:0] q_a;
    logic [WIDTH-1:0] q_b;
  } ramb_out_t;

  ramb_out_t out_r; // Output registers.
  ramb_out_t out_nxt; // Their next value.
  logic [WIDTH-1:0] rd_a; // Word read by port A.
  logic [WIDTH-1:0] rd_b; // Word read by port B.

  // A port writing its own address reads its merged word; enabled
  // lanes carry the new data and masked lanes the stored, which is a
  // legal choice for their don't-care value. The other port reads
  // the array before the edge, so it sees the old data.
  always_comb begin
    rd_a = we_a ? merge(word_a, pa.data, bm_a) : word_a;
    rd_b = we_b ? merge(word_b, pb.data, bm_b) : word_b;
    out_nxt.q_a = rd_a;
    out_nxt.q_b = rd_b;
    if (!RESETN) begin
      out_nxt = '0;
    end
  end

  // The output clear is asynchronous, so outputs drop at once.
  always_ff @(posedge CLOCK or posedge ACLR_OUT) begin
    if (ACLR_OUT) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  // Cleared input registers reach the outputs only through this
  // register, so their effect appears at the next edge.
  assign A_Q = out_r.q_a;
  assign B_Q = out_r.q_b;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  logic [WIDTH-1:0] m0; // Bit mask of lane 0 alone.
  assign m0 = bit_mask(16'h0001);

  out_clear_a: assert property (
    ACLR_OUT |-> (A_Q == '0) && (B_Q == '0)
  ) else $error("Output clear did not empty the outputs.");

  in_clear_a: assert property (
    ACLR_IN |-> !pa.wren && !pb.wren && (pa.addr == '0) && (pa.data == '0)
  ) else $error("Input clear did not empty the input stage.");

  mask_reset_a: assert property (
    $rose(RESETN) |-> (pa.lanes == '1) && (pb.lanes == '1)
  ) else $error("Lane mask not all enabled after reset.");

  mask_noclr_a: assert property (
    ACLR_IN ##1 RESETN |-> pa.lanes == $past(A_LANES)
  ) else $error("Input clear disturbed the lane mask.");

  lane_keep_a: assert property (
    (we_a && !we_b && !lanes_a[0]) |=>
      ((mem[$past(pa.addr)] & m0) == ($past(word_a) & m0))
  ) else $error("Masked lane changed during a write.");

  lane_take_a: assert property (
    (we_a && !we_b) |=>
      ((mem[$past(pa.addr)] & $past(bm_a)) == ($past(pa.data) & $past(bm_a)))
  ) else $error("Enabled lane did not take the new data.");

  // Unwritten words hold unknowns, which a plain equality would flag.
  // Case equality compares them bit for bit instead.
  no_write_a: assert property (
    (!we_a && !we_b) ##1 $stable(pa.addr) |-> (word_a === $past(word_a))
  ) else $error("Storage changed without a write strobe.");

  same_rdw_a: assert property (
    we_a ##1 !ACLR_OUT |-> (A_Q & $past(bm_a)) == ($past(pa.data) & $past(bm_a))
  ) else $error("Same-port read did not show the new data.");

  mixed_rdw_a: assert property (
    (we_b && !we_a && (pa.addr == pb.addr)) ##1 !ACLR_OUT |->
      A_Q == $past(word_a)
  ) else $error("Cross-port read did not return old data.");

  partial_cv: cover property (we_a && (lanes_a[0] != lanes_a[1]));
  rdw_cv: cover property (we_a ##1 !ACLR_OUT);
  mixed_cv: cover property (we_b && (pa.addr == pb.addr));
  clear_cv: cover property (ACLR_IN ##1 ACLR_OUT);

endmodule

/* File: ramb_top_tb.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// Self-checking bench of the small RAM block at width 18.
// ---------------------------------------------------------------------------
module ramb_top_tb;
  localparam int W = 18;
  localparam int AW = 5;
  localparam int MW = 2;

  logic clock = 1'b0; // Bench clock, 50 ns period.
  logic resetn = 1'b0; // Held low for four cycles.
  logic aclr_in = 1'b0; // Input register clear.
  logic aclr_out = 1'b0; // Output register clear.
  logic [AW-1:0] a_addr;
  logic [W-1:0] a_data;
  logic a_wren;
  logic [MW-1:0] a_lanes;
  logic [W-1:0] a_q;
  logic [AW-1:0] b_addr;
  logic [W-1:0] b_data;
  logic b_wren;
  logic [MW-1:0] b_lanes;
  logic [W-1:0] b_q;
  int bad_count = 0; // Mismatches seen.
  int checks_done = 0; // Comparisons made.

  always #25 clock = ~clock;

  ramb_fabric #(.AW(AW), .W(W), .MW(MW)) fab (
    .a_addr(a_addr), .a_data(a_data), .a_wren(a_wren),
    .a_lanes(a_lanes), .b_addr(b_addr), .b_data(b_data),
    .b_wren(b_wren), .b_lanes(b_lanes)
  );

  ramb_top #(.SIZE(ramb_pkg::RAMB_SMALL), .WIDTH(W)) uut (
    .CLOCK(clock), .RESETN(resetn), .ACLR_IN(aclr_in),
    .ACLR_OUT(aclr_out), .A_ADDR(a_addr), .A_DATA(a_data),
    .A_WREN(a_wren), .A_LANES(a_lanes), .A_Q(a_q), .B_ADDR(b_addr),
    .B_DATA(b_data), .B_WREN(b_wren), .B_LANES(b_lanes), .B_Q(b_q)
  );

  // ---------------------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------------------
  // Compares with case equality so an unknown never passes.
  task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp,
                     input string msg);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Two edges of latency, then sample where the output stands settled.
  task automatic wait_q;
    @(posedge clock);
    @(posedge clock);
    @(negedge clock);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Every lane combination, with and without the strobe, over one word.
  task automatic t_lanes;
    logic [W-1:0] ref_w;
    logic [W-1:0] nw;
    logic [W-1:0] m;
    logic [1:0] ln;
    logic wr;
    ref_w = 18'h2a5c3;
    fab.put(1'b0, 5'h03, ref_w, 1'b1, 2'h3);
    wait_q;
    chk(a_q, ref_w, "full write read-through");
    for (int i = 0; i < 8; i++) begin
      ln = 2'(i);
      wr = (i < 4);
      nw = 18'h15a3c + 18'(i);
      m = {{9{ln[1]}}, {9{ln[0]}}};
      if (!wr) begin
        m = '0;
      end
      fab.put(1'b0, 5'h03, nw, wr, ln);
      wait_q;
      ref_w = (nw & m) | (ref_w & ~m);
      chk(a_q, ref_w, "lane merge");
    end
  endtask

  // Port B writes, then A writes while B reads the same word.
  task automatic t_cross;
    fab.put(1'b1, 5'h05, 18'h0f0f0, 1'b1, 2'h3);
    wait_q;
    chk(b_q, 18'h0f0f0, "port b write read-through");
    fab.put(1'b1, 5'h05, 18'h0, 1'b0, 2'h3);
    fab.put(1'b0, 5'h05, 18'h33cc3, 1'b1, 2'h3);
    wait_q;
    chk(b_q, 18'h0f0f0, "cross read during write");
    chk(a_q, 18'h33cc3, "same-port new data");
    @(posedge clock);
    @(negedge clock);
    chk(b_q, 18'h33cc3, "cross read after write");
  endtask

  // Output clear shows without any edge and holds across one.
  task automatic t_aclr_out;
    fab.put(1'b0, 5'h05, 18'h0, 1'b0, 2'h3);
    wait_q;
    aclr_out = 1'b1;
    #5;
    chk(a_q, 18'h0, "output clear at once");
    @(posedge clock);
    @(negedge clock);
    chk(a_q, 18'h0, "output clear held");
    aclr_out = 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk(a_q, 18'h33cc3, "output after clear");
  endtask

  // Input clear turns the address to zero, seen only after an edge.
  task automatic t_aclr_in;
    fab.put(1'b0, 5'h00, 18'h01234, 1'b1, 2'h3);
    wait_q;
    fab.put(1'b0, 5'h07, 18'h3c00f, 1'b1, 2'h3);
    wait_q;
    fab.put(1'b0, 5'h07, 18'h0, 1'b0, 2'h3);
    wait_q;
    aclr_in = 1'b1;
    #5;
    chk(a_q, 18'h3c00f, "input clear waits for edge");
    @(posedge clock);
    @(negedge clock);
    chk(a_q, 18'h01234, "input clear reads address zero");
    aclr_in = 1'b0;
    wait_q;
    chk(a_q, 18'h3c00f, "stored word kept");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  // Reset for four cycles; outputs must read zero while it is held.
  initial begin
    repeat (4) @(negedge clock);
    chk(a_q, 18'h0, "port a output in reset");
    chk(b_q, 18'h0, "port b output in reset");
    resetn = 1'b1;
    t_lanes;
    t_cross;
    t_aclr_out;
    t_aclr_in;
    close_out;
  end

  // The scenarios need about 40 cycles; 400 leaves a wide margin.
  initial begin
    #(400 * 50);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out;
  end
endmodule
